// ---- verilog/relay_timer.sv ----
// Delay timers, toggle relay and calendar time switch with AXI4-Lite registers
`timescale 1ns/10ps
module relay_timer #(
    parameter int TICK_CYCLES = relay_timer_pkg::TICK_CYCLES
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   on_trigger_input,
    input  wire logic                   off_trigger_input,
    input  wire logic                   off_reset,
    input  wire logic                   toggle_trigger_input,
    input  wire logic                   toggle_reset,
    input  wire logic                   power_up,
    input  wire logic                   power_down,
    input  wire relay_timer_pkg::rtc_s  rtc_now,
    output logic                        on_delay_out,
    output logic                        off_delay_out,
    output logic                        toggle_out,
    output logic                        switch_out
);

    // Tick counter is 25 bits wide and needs at least two cycles per tick
    if (TICK_CYCLES < 2 || TICK_CYCLES > 33554431) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [6:0] pin_raw;
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic [6:0] sync3_q;

    assign pin_raw = {power_down, power_up, toggle_reset, toggle_trigger_input,
                      off_reset, off_trigger_input, on_trigger_input};

    for (genvar i = 0; i < 7; i++) begin : g_sync
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sync1_q[i] <= 1'b0;
                sync2_q[i] <= 1'b0;
                sync3_q[i] <= 1'b0;
            end else begin
                sync1_q[i] <= pin_raw[i];
                sync2_q[i] <= sync1_q[i];
                sync3_q[i] <= sync2_q[i];
            end
        end
    end

    logic on_trig;
    logic on_rise;
    logic off_trig;
    logic off_fall;
    logic off_rst;
    logic tog_rise;
    logic tog_rst;
    logic power_evt;

    assign on_trig   = sync2_q[0];
    assign on_rise   = sync2_q[0] & ~sync3_q[0];
    assign off_trig  = sync2_q[1];
    assign off_fall  = ~sync2_q[1] & sync3_q[1];
    assign off_rst   = sync2_q[2];
    assign tog_rise  = sync2_q[3] & ~sync3_q[3];
    assign tog_rst   = sync2_q[4];
    assign power_evt = (sync2_q[5] & ~sync3_q[5]) | (sync2_q[6] & ~sync3_q[6]);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [4:0]   ctrl_q;
    logic [13:0]  on_time_q;
    logic [13:0]  off_time_q;
    logic [6:0]   entry_sel_q;
    logic [31:0]  stage_date_q;
    relay_timer_pkg::entry_s mem [relay_timer_pkg::ENTRIES];
    logic [relay_timer_pkg::ENTRIES-1:0] entry_valid_q;
    logic on_run_q;
    logic off_run_q;

    ////////////////////////////////////////////////////////////////////////////
    // Hundredth-second tick

    logic [24:0] tick_cnt_q;
    logic        tick_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_q <= 25'h0000000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == 25'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= 25'h0000000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 25'h0000001;
            tick_q     <= 1'b0;
        end
    end

    function automatic logic [11:0] unit_div(input logic [1:0] unit);
        unique case (unit)
            relay_timer_pkg::UNIT_MIN:  unit_div = relay_timer_pkg::DIV_MIN;
            relay_timer_pkg::UNIT_HOUR: unit_div = relay_timer_pkg::DIV_HOUR;
            default:                    unit_div = relay_timer_pkg::DIV_SEC;
        endcase
    endfunction : unit_div

    ////////////////////////////////////////////////////////////////////////////
    // On-delay block

    logic [11:0] on_sub_q;
    logic [13:0] on_cnt_q;
    logic        on_step;

    assign on_step = tick_q && (on_sub_q == unit_div(ctrl_q[1:0]) - 12'h001);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_run_q     <= 1'b0;
            on_sub_q     <= 12'h000;
            on_cnt_q     <= 14'h0000;
            on_delay_out <= 1'b0;
        end else if (!on_trig) begin
            on_run_q     <= 1'b0;
            on_delay_out <= 1'b0;
        end else if (on_rise) begin
            on_run_q <= 1'b1;
            on_sub_q <= 12'h000;
            on_cnt_q <= 14'h0000;
        end else if (on_run_q && tick_q) begin
            if (on_step) begin
                on_sub_q <= 12'h000;
                on_cnt_q <= on_cnt_q + 14'h0001;
                if (on_cnt_q + 14'h0001 >= on_time_q) begin
                    on_run_q     <= 1'b0;
                    on_delay_out <= 1'b1;
                end
            end else begin
                on_sub_q <= on_sub_q + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Off-delay block

    logic [11:0] off_sub_q;
    logic [13:0] off_cnt_q;
    logic        off_step;

    assign off_step = tick_q && (off_sub_q == unit_div(ctrl_q[3:2]) - 12'h001);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            off_run_q     <= 1'b0;
            off_sub_q     <= 12'h000;
            off_cnt_q     <= 14'h0000;
            off_delay_out <= 1'b0;
        end else if (off_rst) begin
            off_run_q     <= 1'b0;
            off_cnt_q     <= 14'h0000;
            off_delay_out <= 1'b0;
        end else if (off_trig) begin
            off_run_q     <= 1'b0;
            off_delay_out <= 1'b1;
        end else if (off_fall) begin
            off_run_q <= 1'b1;
            off_sub_q <= 12'h000;
            off_cnt_q <= 14'h0000;
        end else if (off_run_q && tick_q) begin
            if (off_step) begin
                off_sub_q <= 12'h000;
                off_cnt_q <= off_cnt_q + 14'h0001;
                if (off_cnt_q + 14'h0001 >= off_time_q) begin
                    off_run_q     <= 1'b0;
                    off_cnt_q     <= 14'h0000;
                    off_delay_out <= 1'b0;
                end
            end else begin
                off_sub_q <= off_sub_q + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Toggle relay block

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            toggle_out <= 1'b0;
        end else if (tog_rst || power_evt) begin
            toggle_out <= 1'b0;
        end else if (tog_rise) begin
            toggle_out <= ~toggle_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calendar time switch: scans all entries in stored order

    logic [6:0] scan_q;
    logic       acc_q;
    logic       acc_in;
    logic       acc_next;
    logic       applies;
    relay_timer_pkg::entry_s cur;

    assign cur    = mem[scan_q];
    assign acc_in = (scan_q == 7'h00) ? switch_out : acc_q;

    always_comb begin
        if (ctrl_q[relay_timer_pkg::CTRL_WEEK_BIT]) begin
            applies = cur.day_mask[rtc_now.weekday];
        end else begin
            applies = (cur.month == rtc_now.month) && (cur.day == rtc_now.day);
        end
        applies  = applies && entry_valid_q[scan_q];
        acc_next = acc_in;
        if (applies) begin
            if (cur.on_en && rtc_now.minute >= cur.on_min) begin
                acc_next = 1'b1;
            end
            if (cur.off_en && rtc_now.minute >= cur.off_min) begin
                acc_next = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scan_q     <= 7'h00;
            acc_q      <= 1'b0;
            switch_out <= 1'b0;
        end else if (scan_q == 7'(relay_timer_pkg::ENTRIES - 1)) begin
            scan_q     <= 7'h00;
            switch_out <= acc_next;
        end else begin
            scan_q <= scan_q + 7'h01;
            acc_q  <= acc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    logic       aw_have_q;
    logic       w_have_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] wr_old;
    logic [31:0] wr_new;
    logic        wr_hit;

    function automatic logic [31:0] read_reg(input logic [7:0] addr);
        relay_timer_pkg::entry_s e;
        e = mem[entry_sel_q];
        unique case (addr)
            relay_timer_pkg::CTRL_OFF:       read_reg = {27'h0, ctrl_q};
            relay_timer_pkg::ON_TIME_OFF:    read_reg = {18'h0, on_time_q};
            relay_timer_pkg::OFF_TIME_OFF:   read_reg = {18'h0, off_time_q};
            relay_timer_pkg::STATUS_OFF:     read_reg = {26'h0, off_run_q, on_run_q, switch_out,
                                                         toggle_out, off_delay_out, on_delay_out};
            relay_timer_pkg::ENTRY_SEL_OFF:  read_reg = {25'h0, entry_sel_q};
            relay_timer_pkg::ENTRY_DATE_OFF: read_reg = entry_valid_q[entry_sel_q] ?
                                                        {14'h0, e.day, e.month, e.day_mask, e.off_en, e.on_en} :
                                                        32'h00000000;
            relay_timer_pkg::ENTRY_TIME_OFF: read_reg = entry_valid_q[entry_sel_q] ?
                                                        {5'h0, e.off_min, 5'h0, e.on_min} : 32'h00000000;
            default:                         read_reg = 32'h00000000;
        endcase
    endfunction : read_reg

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr[1:0] == 2'h0) && (addr <= relay_timer_pkg::ENTRY_TIME_OFF);
    endfunction : mapped

    function automatic logic [13:0] clamp_delay(input logic [31:0] v);
        if (v[13:0] < relay_timer_pkg::DELAY_MIN || v[31:14] != 18'h0) begin
            clamp_delay = (v == 32'h00000000) ? relay_timer_pkg::DELAY_MIN : relay_timer_pkg::DELAY_MAX;
        end else if (v[13:0] > relay_timer_pkg::DELAY_MAX) begin
            clamp_delay = relay_timer_pkg::DELAY_MAX;
        end else begin
            clamp_delay = v[13:0];
        end
    endfunction : clamp_delay

    assign wr_old = (waddr_q == relay_timer_pkg::ENTRY_DATE_OFF) ? stage_date_q : read_reg(waddr_q);
    assign wr_hit = aw_have_q && w_have_q && !s_axi_bvalid;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wr_new[b*8 +: 8] = wstrb_q[b] ? wdata_q[b*8 +: 8] : wr_old[b*8 +: 8];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            waddr_q       <= 8'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= relay_timer_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                waddr_q       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_hit) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(waddr_q) ? relay_timer_pkg::RESP_OKAY : relay_timer_pkg::RESP_DECERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q        <= relay_timer_pkg::CTRL_RST;
            on_time_q     <= relay_timer_pkg::DELAY_RST;
            off_time_q    <= relay_timer_pkg::DELAY_RST;
            entry_sel_q   <= 7'h00;
            stage_date_q  <= 32'h00000000;
            entry_valid_q <= '0;
        end else if (wr_hit) begin
            unique case (waddr_q)
                relay_timer_pkg::CTRL_OFF:       ctrl_q      <= wr_new[4:0];
                relay_timer_pkg::ON_TIME_OFF:    on_time_q   <= clamp_delay(wr_new);
                relay_timer_pkg::OFF_TIME_OFF:   off_time_q  <= clamp_delay(wr_new);
                relay_timer_pkg::ENTRY_SEL_OFF:  entry_sel_q <= (wr_new[6:0] == 7'h7f) ? 7'h7e : wr_new[6:0];
                relay_timer_pkg::ENTRY_DATE_OFF: stage_date_q <= wr_new;
                relay_timer_pkg::ENTRY_TIME_OFF: entry_valid_q[entry_sel_q] <= 1'b1;
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (wr_hit && waddr_q == relay_timer_pkg::ENTRY_TIME_OFF) begin
            mem[entry_sel_q] <= '{on_en:    stage_date_q[0],
                                  off_en:   stage_date_q[1],
                                  day_mask: stage_date_q[8:2],
                                  month:    stage_date_q[12:9],
                                  day:      stage_date_q[17:13],
                                  on_min:   wr_new[10:0],
                                  off_min:  wr_new[26:16]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= relay_timer_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= mapped(s_axi_araddr) ? read_reg(s_axi_araddr) : 32'h00000000;
            s_axi_rresp   <= mapped(s_axi_araddr) ? relay_timer_pkg::RESP_OKAY : relay_timer_pkg::RESP_DECERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule : relay_timer

// ---- verilog/relay_timer_pkg.sv ----
// Shared constants and types for the delay, toggle and calendar switch block
package relay_timer_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF       = 8'h00;
    localparam logic [7:0] ON_TIME_OFF    = 8'h04;
    localparam logic [7:0] OFF_TIME_OFF   = 8'h08;
    localparam logic [7:0] STATUS_OFF     = 8'h0c;
    localparam logic [7:0] ENTRY_SEL_OFF  = 8'h10;
    localparam logic [7:0] ENTRY_DATE_OFF = 8'h14;
    localparam logic [7:0] ENTRY_TIME_OFF = 8'h18;

    // Control field positions
    localparam int CTRL_ON_UNIT_LSB  = 0;
    localparam int CTRL_OFF_UNIT_LSB = 2;
    localparam int CTRL_WEEK_BIT     = 4;

    // Reset values and delay clamp limits
    localparam logic [4:0]  CTRL_RST     = 5'h00;
    localparam logic [13:0] DELAY_RST    = 14'h0064;
    localparam logic [13:0] DELAY_MIN    = 14'h0001;
    localparam logic [13:0] DELAY_MAX    = 14'h270f;

    // Time units
    localparam logic [1:0] UNIT_SEC  = 2'h0;
    localparam logic [1:0] UNIT_MIN  = 2'h1;
    localparam logic [1:0] UNIT_HOUR = 2'h2;

    // Hundredth ticks per hundredth of a unit
    localparam logic [11:0] DIV_SEC  = 12'h001;
    localparam logic [11:0] DIV_MIN  = 12'h03c;
    localparam logic [11:0] DIV_HOUR = 12'he10;

    // Time base
    localparam int CLK_PERIOD_NS = 5;
    localparam int HUNDREDTH_NS  = 10000000;
    localparam int TICK_CYCLES   = HUNDREDTH_NS / CLK_PERIOD_NS;

    // Switch table
    localparam int ENTRIES = 127;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic       on_en;
        logic       off_en;
        logic [6:0] day_mask;
        logic [3:0] month;
        logic [4:0] day;
        logic [10:0] on_min;
        logic [10:0] off_min;
    } entry_s;

    typedef struct packed {
        logic [2:0]  weekday;
        logic [3:0]  month;
        logic [4:0]  day;
        logic [10:0] minute;
    } rtc_s;

endpackage : relay_timer_pkg

// ---- verification/relay_timer_assertions.sv ----
// Concurrent checks on the relay timer ports
`timescale 1ns/10ps
module relay_timer_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic on_trigger_input,
    input wire logic off_trigger_input,
    input wire logic off_reset,
    input wire logic toggle_trigger_input,
    input wire logic toggle_reset,
    input wire logic power_up,
    input wire logic power_down,
    input wire logic on_delay_out,
    input wire logic off_delay_out,
    input wire logic toggle_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire calm = !toggle_reset && !power_up && !power_down;
    ////////////////////////////////////////////////////////////
    sequence tog_idle_s;
        (!toggle_trigger_input && calm)[*6];
    endsequence
    sequence tog_rise_s;
        tog_idle_s ##1 (toggle_trigger_input && calm)[*6];
    endsequence
    a_on_low_clear: assert property ((!on_trigger_input)[*5] |-> !on_delay_out)
        else $error("on-delay output high with trigger low");
    a_off_trig_set: assert property ((off_trigger_input && !off_reset)[*5] |-> off_delay_out)
        else $error("off-delay output low with trigger high");
    a_off_rst_clear: assert property (off_reset[*5] |-> !off_delay_out)
        else $error("off-delay output high under reset");
    a_tog_rst_clear: assert property (toggle_reset[*5] |-> !toggle_out)
        else $error("toggle output high under reset");
    a_tog_rise_flip: assert property (tog_rise_s |-> toggle_out != $past(toggle_out, 6))
        else $error("toggle output did not invert on trigger rise");
    a_tog_quiet_hold: assert property (tog_idle_s |-> $stable(toggle_out))
        else $error("toggle output changed without trigger rise");
    a_wr_resp_time: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_rd_answer_now: assert property ((s_axi_arvalid && s_axi_arready) |=> (s_axi_rvalid && !s_axi_arready))
        else $error("read answer late");
endmodule : relay_timer_assertions
bind relay_timer relay_timer_assertions chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .on_trigger_input,
    .off_trigger_input, .off_reset, .toggle_trigger_input, .toggle_reset, .power_up, .power_down,
    .on_delay_out, .off_delay_out, .toggle_out);

// ---- verification/field_side.sv ----
// Field side model: input contacts and calendar clock
`timescale 1ns/10ps
module field_side (
    input  wire logic                  aclk,
    input  wire logic [6:0]            want,
    input  wire relay_timer_pkg::rtc_s want_now,
    output logic [6:0]                 contacts = 7'h00,
    output relay_timer_pkg::rtc_s      rtc_now = '0
);
    // Contacts settle one cycle after a request
    always @(posedge aclk) begin
        contacts <= want;
    end
    // Weekday 0 is Monday through 6 Sunday
    always @(posedge aclk) begin
        rtc_now <= want_now;
    end
endmodule : field_side

// ---- verification/relay_timer_tb.sv ----
// Self-checking bench for the relay timer block
`timescale 1ns/10ps
module relay_timer_tb;
    localparam int TK = 4;
    logic                  aclk = 1'b0;
    logic                  aresetn = 1'b0;
    logic [7:0]            s_axi_awaddr = 8'h00;
    logic                  s_axi_awvalid = 1'b0;
    logic [31:0]           s_axi_wdata = 32'h0;
    logic [3:0]            s_axi_wstrb = 4'hf;
    logic                  s_axi_wvalid = 1'b0;
    logic                  s_axi_bready = 1'b0;
    logic [7:0]            s_axi_araddr = 8'h00;
    logic                  s_axi_arvalid = 1'b0;
    logic                  s_axi_rready = 1'b0;
    logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]            s_axi_bresp, s_axi_rresp;
    logic [31:0]           s_axi_rdata;
    logic                  on_delay_out, off_delay_out, toggle_out, switch_out;
    logic [6:0]            want = 7'h00;
    logic [6:0]            pins;
    relay_timer_pkg::rtc_s now = '0;
    relay_timer_pkg::rtc_s rtc;
    int                    miscompares = 0;
    int                    compares = 0;
    int                    cycles = 0;
    int                    seed = 32'haccc6b62;
    int                    n;
    relay_timer #(.TICK_CYCLES(TK)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .on_trigger_input(pins[0]), .off_trigger_input(pins[1]), .off_reset(pins[2]),
        .toggle_trigger_input(pins[3]), .toggle_reset(pins[4]), .power_up(pins[5]),
        .power_down(pins[6]), .rtc_now(rtc), .on_delay_out, .off_delay_out, .toggle_out, .switch_out
    );
    field_side fs (.aclk, .want, .want_now(now), .contacts(pins), .rtc_now(rtc));
    ////////////////////////////////////////////////////////////
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            miscompares++;
            close_out();
        end
    end
    task close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    function automatic logic [1:0] rsp(input logic [7:0] a);
        return (a > relay_timer_pkg::ENTRY_TIME_OFF || a[1:0] != 2'h0) ?
            relay_timer_pkg::RESP_DECERR : relay_timer_pkg::RESP_OKAY;
    endfunction : rsp
    function automatic int dly(input int u, input int t);
        return t * TK * (u == 0 ? 1 : u == 1 ? 60 : 3600);
    endfunction : dly
    function automatic logic [31:0] dt(input logic [1:0] en, input logic [6:0] mk);
        return {14'h0, 5'h05, 4'h3, mk, en};
    endfunction : dt
    task cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask : cyc
    task p(input int i, input logic v);
        @(posedge aclk);
        want[i] <= v;
    endtask : p
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, rsp(a));
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, rsp(a));
    endtask : rd
    task tg;
        p(3, 1'b1);
        cyc(5);
        p(3, 1'b0);
        cyc(5);
    endtask : tg
    task ent(input logic [6:0] s, input logic [1:0] en, input logic [6:0] mk, input logic [10:0] on,
             input logic [10:0] off);
        wr(relay_timer_pkg::ENTRY_SEL_OFF, {25'h0, s});
        wr(relay_timer_pkg::ENTRY_DATE_OFF, dt(en, mk));
        wr(relay_timer_pkg::ENTRY_TIME_OFF, {5'h0, off, 5'h0, on});
    endtask : ent
    task at(input logic [2:0] w, input logic [10:0] m, input logic e);
        @(posedge aclk);
        now <= {w, 4'h3, 5'h05, m};
        cyc(300);
        chk(switch_out, e);
    endtask : at
    ////////////////////////////////////////////////////////////
    initial begin
        cyc(16);
        aresetn <= 1'b1;
        rd(relay_timer_pkg::CTRL_OFF, 32'h0);
        rd(relay_timer_pkg::ON_TIME_OFF, 32'(relay_timer_pkg::DELAY_RST));
        rd(relay_timer_pkg::STATUS_OFF, 32'h0);
        rd(8'h1c, 32'h0);
        rd(8'h06, 32'h0);
        wr(8'h20, 32'h1);
        wr(relay_timer_pkg::ON_TIME_OFF, 32'h0);
        rd(relay_timer_pkg::ON_TIME_OFF, 32'(relay_timer_pkg::DELAY_MIN));
        wr(relay_timer_pkg::ON_TIME_OFF, 32'h2710);
        rd(relay_timer_pkg::ON_TIME_OFF, 32'(relay_timer_pkg::DELAY_MAX));
        n = 1 + $unsigned($random(seed)) % 9999;
        wr(relay_timer_pkg::OFF_TIME_OFF, 32'(n));
        rd(relay_timer_pkg::OFF_TIME_OFF, 32'(n));
        for (int u = 0; u < 3; u++) begin
            wr(relay_timer_pkg::CTRL_OFF, 32'(u));
            wr(relay_timer_pkg::ON_TIME_OFF, 32'h2);
            p(0, 1'b1);
            cyc(dly(u, 1));
            p(0, 1'b0);
            cyc(8);
            p(0, 1'b1);
            cyc(dly(u, 2) - TK - 2);
            chk(on_delay_out, 0);
            cyc(2 * TK + 12);
            chk(on_delay_out, 1);
            p(0, 1'b0);
            cyc(6);
            chk(on_delay_out, 0);
        end
        wr(relay_timer_pkg::CTRL_OFF, 32'h0);
        wr(relay_timer_pkg::OFF_TIME_OFF, 32'h5);
        p(1, 1'b1);
        cyc(6);
        chk(off_delay_out, 1);
        p(1, 1'b0);
        cyc(12);
        chk(off_delay_out, 1);
        p(1, 1'b1);
        p(1, 1'b0);
        cyc(14);
        chk(off_delay_out, 1);
        cyc(20);
        chk(off_delay_out, 0);
        p(1, 1'b1);
        cyc(4);
        p(1, 1'b0);
        cyc(4);
        p(2, 1'b1);
        cyc(6);
        chk(off_delay_out, 0);
        p(1, 1'b1);
        cyc(6);
        chk(off_delay_out, 0);
        p(2, 1'b0);
        p(1, 1'b0);
        n = 1 + $unsigned($random(seed)) % 8;
        repeat (n) tg();
        chk(toggle_out, n % 2);
        repeat (n % 2) tg();
        @(posedge aclk);
        want <= want | 7'h18;
        cyc(8);
        chk(toggle_out, 0);
        p(4, 1'b0);
        p(3, 1'b0);
        tg();
        chk(toggle_out, 1);
        p(4, 1'b1);
        cyc(6);
        chk(toggle_out, 0);
        p(4, 1'b0);
        for (int k = 5; k < 7; k++) begin
            tg();
            p(k, 1'b1);
            cyc(6);
            chk(toggle_out, 0);
            p(k, 1'b0);
        end
        ent(7'h00, 2'h3, 7'h00, 11'h064, 11'h0c8);
        ent(7'h01, 2'h1, 7'h00, 11'h12c, 11'h000);
        ent(7'h02, 2'h2, 7'h00, 11'h000, 11'h190);
        at(3'h0, 11'h032, 0);
        at(3'h0, 11'h096, 1);
        at(3'h0, 11'h0fa, 0);
        at(3'h0, 11'h140, 1);
        at(3'h0, 11'h19a, 0);
        wr(relay_timer_pkg::CTRL_OFF, 32'h10);
        ent(7'h03, 2'h1, 7'h7f, 11'h00a, 11'h000);
        ent(7'h7e, 2'h2, 7'h01, 11'h000, 11'h1f4);
        at(3'h1, 11'h258, 1);
        at(3'h0, 11'h258, 0);
        rd(relay_timer_pkg::ENTRY_DATE_OFF, dt(2'h2, 7'h01));
        close_out();
    end
endmodule : relay_timer_tb
